// >>> core/slc_top.v
/*
 link connect/disconnect and no-amplifier mode command interpreter,
 with an AHB-Lite register slave.
 assumes one 20 MHz clock, a synchronous reset, single-word transfers
 and an external link engine that reports its chain and the driver line
*/
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module slc_top #(
	parameter CYC_DIV = 17760,
	parameter NAX     = 32
) (
	// clock and reset
	input  wire        CLK,
	input  wire        RST,
	// ahb-lite slave
	input  wire        HSEL,
	input  wire [31:0] HADDR,
	input  wire [1:0]  HTRANS,
	input  wire        HWRITE,
	input  wire [2:0]  HSIZE,
	input  wire [31:0] HWDATA,
	input  wire        HREADY,
	output wire        HREADYOUT,
	output wire        HRESP,
	output reg  [31:0] HRDATA,
	// link side
	input  wire [NAX-1:0] AXIS_PRESENT,
	input  wire [NAX-1:0] AXIS_SECONDARY,
	input  wire        DRIVER_COMM_LINE,
	input  wire        FORCED_STOP_INPUT,
	output reg  [NAX-1:0] AXIS_CONNECTED,
	output reg         NO_AMP_MODE_STATUS,
	output reg         FORCED_STOP_ACTIVE
);
`include "slc_map.vh"

	// ------------------------------------------------------------
	// states
	// ------------------------------------------------------------
	localparam ST_IDLE = 3'b001;
	localparam ST_WAIT = 3'b010;
	localparam ST_BUSY = 3'b100;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	reg [NAX-1:0] pres_m_q, pres_q, sec_m_q, sec_q;
	reg           drv_m_q, drv_q, estop_m_q, estop_q;

	always @(posedge CLK) begin
		pres_m_q  <= AXIS_PRESENT;
		pres_q    <= pres_m_q;
		sec_m_q   <= AXIS_SECONDARY;
		sec_q     <= sec_m_q;
		drv_m_q   <= DRIVER_COMM_LINE;
		drv_q     <= drv_m_q;
		estop_m_q <= FORCED_STOP_INPUT;
		estop_q   <= estop_m_q;
	end

	// ------------------------------------------------------------
	// operation cycle
	// ------------------------------------------------------------
	wire tick;

	slc_tick #(
		.DIV (CYC_DIV)
	) u_tick (
		.clk  (CLK),
		.rst  (RST),
		.tick (tick)
	);

	// ------------------------------------------------------------
	// ahb-lite slave
	// ------------------------------------------------------------
	reg        dph_wr_q;
	reg [3:0]  dph_ofs_q;
	reg [15:0] cmd_q;
	reg [15:0] stat_q;
	reg        sim_q;
	reg        sim_ign_q;
	reg [2:0]  st_q;
	reg [2:0]  req_q;
	reg [4:0]  req_ax_q;
	reg [15:0] busy_q;
	wire       aph = HSEL & HREADY & HTRANS[1];
	// only the first four words are mapped
	wire       hit = (HADDR[31:4] == 28'h000_0000);

	assign HREADYOUT = 1'b1;
	assign HRESP     = 1'b0;

	always @(posedge CLK) begin
		if (RST) begin
			dph_wr_q  <= 1'b0;
			dph_ofs_q <= 4'h0;
		end else begin
			dph_wr_q  <= aph & HWRITE & hit;
			dph_ofs_q <= {HADDR[3:2], 2'b00};
		end
	end

	// read word chosen at the address phase
	reg [31:0] rd_d;

	always @* begin
		rd_d = 32'h0000_0000;
		if (hit) begin
			case ({HADDR[3:2], 2'b00})
			`SLC_OFS_CMD:   rd_d = {16'h0000, cmd_q};
			`SLC_OFS_STAT:  rd_d = {16'h0000, stat_q};
			`SLC_OFS_FLAG:  rd_d = {30'h0000_0000, sim_ign_q, sim_q};
			`SLC_OFS_AXCTL: rd_d = AXIS_CONNECTED;
			default:        rd_d = 32'h0000_0000;
			endcase
		end
	end

	// read data registered at the address phase
	always @(posedge CLK) begin
		if (RST) begin
			HRDATA <= 32'h0000_0000;
		end else if (aph & ~HWRITE) begin
			HRDATA <= rd_d;
		end
	end

	wire cmd_wr = dph_wr_q & (dph_ofs_q == `SLC_OFS_CMD);

	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	wire is_axis = (cmd_q >= `SLC_AXIS_MIN) & (cmd_q <= `SLC_AXIS_MAX);
	wire [4:0] axn = cmd_q[4:0] - 5'h01;
	wire drv_ok = ~drv_q | (axn == 5'h00);
	wire can_disc = is_axis & AXIS_CONNECTED[axn] & pres_q[axn] & drv_ok;
	wire is_conn  = (cmd_q == `SLC_CMD_CONNECT);
	wire is_sim   = (cmd_q == `SLC_CMD_SIM1) | (cmd_q == `SLC_CMD_SIM2);
	wire is_rel   = (cmd_q == `SLC_CMD_REL);

	// downstream mask: named axis and all after it
	reg [NAX-1:0] down_mask;
	reg [NAX-1:0] conn_mask;
	integer i;
	always @* begin
		down_mask = {NAX{1'b0}};
		conn_mask = {NAX{1'b0}};
		for (i = 0; i < NAX; i = i + 1) begin
			if (i >= req_ax_q)
				down_mask[i] = 1'b1;
			if (pres_q[i] & ~sec_q[i] & (~drv_q | (i == 0)))
				conn_mask[i] = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// command register: host writes, cleared only by host or reset
	// ------------------------------------------------------------
	always @(posedge CLK) begin
		if (RST)
			cmd_q <= `SLC_CMD_NONE;
		else if (cmd_wr)
			cmd_q <= HWDATA[15:0];
	end

	// ------------------------------------------------------------
	// accept decode: request the idle state would take
	// ------------------------------------------------------------
	reg       acc_ok;
	reg [2:0] acc_req;

	always @* begin
		acc_ok  = 1'b0;
		acc_req = `SLC_REQ_DISC;
		if (sim_q) begin
			if (is_rel) begin
				acc_ok  = 1'b1;
				acc_req = `SLC_REQ_REL;
			end
		end else if (can_disc) begin
			acc_ok  = 1'b1;
			acc_req = `SLC_REQ_DISC;
		end else if (is_conn) begin
			acc_ok  = 1'b1;
			acc_req = `SLC_REQ_CONN;
		end else if (is_sim) begin
			acc_ok  = 1'b1;
			acc_req = (cmd_q == `SLC_CMD_SIM1) ?
				`SLC_REQ_SIM1 : `SLC_REQ_SIM2;
		end
	end

	// ------------------------------------------------------------
	// sequencer: next values, taken only on the operation tick
	// ------------------------------------------------------------
	reg [2:0]     st_d;
	reg [15:0]    stat_d;
	reg [2:0]     req_d;
	reg [4:0]     req_ax_d;
	reg [15:0]    busy_d;
	reg           sim_d;
	reg           sim_ign_d;
	reg [NAX-1:0] conn_d;

	always @* begin
		st_d      = st_q;
		stat_d    = stat_q;
		req_d     = req_q;
		req_ax_d  = req_ax_q;
		busy_d    = busy_q;
		sim_d     = sim_q;
		sim_ign_d = sim_ign_q;
		conn_d    = AXIS_CONNECTED;
		case (st_q)
		ST_IDLE: begin
			if (acc_ok) begin
				req_d    = acc_req;
				req_ax_d = axn;
				st_d     = ST_WAIT;
				stat_d   = `SLC_ST_WAIT;
			end
		end
		ST_WAIT: begin
			if (cmd_q == `SLC_CMD_EXEC) begin
				st_d   = ST_BUSY;
				busy_d = `SLC_BUSY_CYC;
				stat_d = `SLC_ST_BUSY;
			end
		end
		ST_BUSY: begin
			if (busy_q != `SLC_BUSY_NONE) begin
				busy_d = busy_q - `SLC_BUSY_STEP;
			end else begin
				case (req_q)
				`SLC_REQ_DISC:
					conn_d = AXIS_CONNECTED & ~down_mask;
				`SLC_REQ_CONN:
					conn_d = AXIS_CONNECTED | conn_mask;
				`SLC_REQ_SIM1: begin
					sim_d     = 1'b1;
					sim_ign_d = 1'b1;
				end
				`SLC_REQ_SIM2: begin
					sim_d     = 1'b1;
					sim_ign_d = 1'b0;
				end
				`SLC_REQ_REL: begin
					sim_d     = 1'b0;
					sim_ign_d = 1'b0;
				end
				default: begin
					sim_d     = sim_q;
					sim_ign_d = sim_ign_q;
				end
				endcase
				st_d   = ST_IDLE;
				stat_d = `SLC_ST_ACCEPT;
			end
		end
		default: begin
			st_d   = ST_IDLE;
			stat_d = `SLC_ST_ACCEPT;
		end
		endcase
	end

	// ------------------------------------------------------------
	// sequencer: registers
	// ------------------------------------------------------------
	always @(posedge CLK) begin
		if (RST) begin
			st_q           <= ST_IDLE;
			stat_q         <= `SLC_ST_ACCEPT;
			req_q          <= `SLC_REQ_DISC;
			req_ax_q       <= 5'h00;
			busy_q         <= `SLC_BUSY_NONE;
			sim_q          <= 1'b0;
			sim_ign_q      <= 1'b0;
			AXIS_CONNECTED <= {NAX{1'b1}};
		end else if (tick) begin
			st_q           <= st_d;
			stat_q         <= stat_d;
			req_q          <= req_d;
			req_ax_q       <= req_ax_d;
			busy_q         <= busy_d;
			sim_q          <= sim_d;
			sim_ign_q      <= sim_ign_d;
			AXIS_CONNECTED <= conn_d;
		end
	end

	// ------------------------------------------------------------
	// status outputs
	// ------------------------------------------------------------
	always @(posedge CLK) begin
		if (RST) begin
			NO_AMP_MODE_STATUS <= 1'b0;
			FORCED_STOP_ACTIVE <= 1'b0;
		end else begin
			NO_AMP_MODE_STATUS <= sim_q;
			FORCED_STOP_ACTIVE <= estop_q & ~sim_ign_q;
		end
	end
endmodule
`default_nettype wire

// >>> core/slc_map.vh
/*
 header of constants for the link connect and no-amp mode block
 assumes inclusion by its bare name from core design files
*/
`ifndef SLC_MAP_VH
`define SLC_MAP_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SLC_OFS_CMD        4'h0
`define SLC_OFS_STAT       4'h4
`define SLC_OFS_FLAG       4'h8
`define SLC_OFS_AXCTL      4'hC
// ----------------------------------------------------------------
// command codes, 16-bit two's complement
// ----------------------------------------------------------------
`define SLC_CMD_NONE       16'h0000
`define SLC_CMD_EXEC       16'hFFFE
`define SLC_CMD_CONNECT    16'hFFF6
`define SLC_CMD_SIM1       16'hFFEC
`define SLC_CMD_SIM2       16'hFFEB
`define SLC_CMD_REL        16'hFFE7
`define SLC_AXIS_MIN       16'h0001
`define SLC_AXIS_MAX       16'h0020
// ----------------------------------------------------------------
// status codes
// ----------------------------------------------------------------
`define SLC_ST_ACCEPT      16'h0000
`define SLC_ST_WAIT        16'hFFFF
`define SLC_ST_BUSY        16'hFFFE
// ----------------------------------------------------------------
// pending request kinds
// ----------------------------------------------------------------
`define SLC_REQ_DISC       3'h0
`define SLC_REQ_CONN       3'h1
`define SLC_REQ_SIM1       3'h2
`define SLC_REQ_SIM2       3'h3
`define SLC_REQ_REL        3'h4
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SLC_CYCLE_NS       888000
`define SLC_CLK_NS         50
`define SLC_BUSY_CYC       16'h0004
`define SLC_BUSY_NONE      16'h0000
`define SLC_BUSY_STEP      16'h0001
`endif

// >>> core/slc_tick.v
/*
 operation-cycle divider: one-cycle enable pulse every DIV clocks
 assumes a single clock and a synchronous active-high reset
*/
`timescale 1ns/10ps
`default_nettype none
module slc_tick #(
	parameter DIV = 17760
) (
	// clock and reset
	input  wire clk,
	input  wire rst,
	// enable out
	output reg  tick
);
	reg [31:0] cnt_q;

	always @(posedge clk) begin
		if (rst) begin
			cnt_q <= 32'h0000_0000;
			tick  <= 1'b0;
		end else if (cnt_q >= DIV - 1) begin
			cnt_q <= 32'h0000_0000;
			tick  <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 32'h0000_0001;
			tick  <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> tb/slc_props.sv
/*
 port assertions for slc_top
 assumes bind into slc_top, one clock, sync reset
*/
`timescale 1ns/10ps
`default_nettype none
module slc_props #(
	parameter NAX = 32
) (
	// clock, reset, bus
	input wire logic           CLK,
	input wire logic           RST,
	input wire logic           HREADYOUT,
	input wire logic           HRESP,
	input wire logic [31:0]    HRDATA,
	// link side
	input wire logic [NAX-1:0] AXIS_SECONDARY,
	input wire logic           DRIVER_COMM_LINE,
	input wire logic           FORCED_STOP_INPUT,
	input wire logic [NAX-1:0] AXIS_CONNECTED,
	input wire logic           NO_AMP_MODE_STATUS,
	input wire logic           FORCED_STOP_ACTIVE
);
	logic [NAX-1:0] prev_q;
	wire  [NAX-1:0] fall = prev_q & ~AXIS_CONNECTED;
	wire  [NAX-1:0] rise = ~prev_q & AXIS_CONNECTED;
	always @(posedge CLK) prev_q <= AXIS_CONNECTED;
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	sequence s_stop_held;
		(FORCED_STOP_INPUT && !NO_AMP_MODE_STATUS) [*6];
	endsequence
	AST_RDY: assert property (HREADYOUT)
		else $error("hreadyout low");
	AST_OKAY: assert property (!HRESP)
		else $error("hresp not okay");
	AST_RST: assert property ($fell(RST) |->
		!NO_AMP_MODE_STATUS && &AXIS_CONNECTED && HRDATA == '0)
		else $error("bad state after reset");
	AST_STOP: assert property (s_stop_held |-> FORCED_STOP_ACTIVE)
		else $error("forced stop not passed");
	AST_SIM: assert property (NO_AMP_MODE_STATUS &&
		$past(NO_AMP_MODE_STATUS) |-> $stable(AXIS_CONNECTED))
		else $error("link changed in no-amp mode");
	AST_DOWN: assert property (fall != '0 |->
		(AXIS_CONNECTED & ~((fall & -fall) - 1'b1)) == '0)
		else $error("downstream axis still linked");
	AST_SEC: assert property ((rise & AXIS_SECONDARY) == '0)
		else $error("secondary axis relinked");
	AST_DRV: assert property (DRIVER_COMM_LINE &&
		(fall | rise) != '0 |-> (fall[0] || rise[0]) && !(|rise[NAX-1:1]))
		else $error("link change beyond first axis");
	AST_MODE: assert property ($changed(NO_AMP_MODE_STATUS) |=>
		$stable(NO_AMP_MODE_STATUS) [*8])
		else $error("mode changed too soon");
endmodule
bind slc_top slc_props #(.NAX(NAX)) u_props (.CLK, .RST, .HREADYOUT,
	.HRESP, .HRDATA, .AXIS_SECONDARY, .DRIVER_COMM_LINE,
	.FORCED_STOP_INPUT, .AXIS_CONNECTED, .NO_AMP_MODE_STATUS,
	.FORCED_STOP_ACTIVE);
`default_nettype wire

// >>> tb/slc_amp.sv
/*
 amplifier chain model on the link side
 assumes the bench asks for power per axis
*/
`timescale 1ns/10ps
`default_nettype none
module slc_amp #(
	parameter NAX = 32
) (
	// clock
	input  wire logic           clk,
	// bench and block side
	input  wire logic [NAX-1:0] pwr_req,
	input  wire logic [NAX-1:0] connected,
	output var  logic [NAX-1:0] present
);
	always @(posedge clk) present <= pwr_req | connected;
endmodule
`default_nettype wire

// >>> tb/slc_top_tb.sv
/*
 self-checking bench for slc_top
 assumes slc_amp partner and the slc_props bind
*/
`timescale 1ns/10ps
`default_nettype none
module slc_top_tb;
	logic        clk = 0;
	logic        rst = 1;
	logic        hsel = 0;
	logic        hwr = 0;
	logic        drv = 0;
	logic        fstop = 1;
	logic [1:0]  htr = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwd = 32'h0;
	logic [31:0] pwr = 32'hFFFF_FFFF;
	logic [31:0] sec = 32'h200;
	logic [31:0] links = 32'hFFFF_FFFF;
	logic [31:0] rd;
	wire         rdy, resp, mode, fsa;
	wire  [31:0] hrd, conn, pres;
	int          num_errors = 0;
	int          n_compared = 0;
	always #25 clk = ~clk;
	slc_amp u_amp (.clk, .pwr_req(pwr), .connected(conn), .present(pres));
	slc_top #(.CYC_DIV(4)) uut (.CLK(clk), .RST(rst), .HSEL(hsel),
		.HADDR(haddr), .HTRANS(htr), .HWRITE(hwr), .HSIZE(3'h2),
		.HWDATA(hwd), .HREADY(rdy), .HREADYOUT(rdy), .HRESP(resp),
		.HRDATA(hrd), .AXIS_PRESENT(pres), .AXIS_SECONDARY(sec),
		.DRIVER_COMM_LINE(drv), .FORCED_STOP_INPUT(fstop),
		.AXIS_CONNECTED(conn), .NO_AMP_MODE_STATUS(mode),
		.FORCED_STOP_ACTIVE(fsa));
	task automatic chk(input logic [31:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic [31:0] a, d, input logic w);
		@(posedge clk);
		hsel <= 1'b1;
		htr <= 2'h2;
		haddr <= a;
		hwr <= w;
		do @(posedge clk); while (rdy !== 1'b1);
		hsel <= 1'b0;
		htr <= 2'h0;
		hwd <= d;
		do @(posedge clk); while (rdy !== 1'b1);
		rd = hrd;
	endtask
	task automatic poll(input logic [31:0] v);
		for (int i = 0; i < 40; i++) begin
			bus(32'h4, 32'h0, 1'b0);
			if (rd === v)
				break;
		end
		chk(rd, v);
	endtask
	task automatic op(input logic [31:0] code, cexp);
		bus(32'h0, code, 1'b1);
		poll(32'hFFFF);
		chk(conn, links);
		bus(32'h0, 32'hFFFE, 1'b1);
		poll(32'hFFFE);
		poll(32'h0);
		bus(32'h0, 32'h0, 1'b1);
		chk(conn, cexp);
		links = cexp;
	endtask
	task automatic refuse(input logic [31:0] code);
		bus(32'h0, code, 1'b1);
		repeat (6) begin
			bus(32'h4, 32'h0, 1'b0);
			chk(rd, 32'h0);
		end
		bus(32'h0, 32'h0, 1'b1);
	endtask
	task automatic t_reset;
		bus(32'h4, 32'h0, 1'b0);
		chk(rd, 32'h0);
		bus(32'h8, 32'h0, 1'b0);
		chk(rd, 32'h0);
		bus(32'hC, 32'h0, 1'b0);
		chk(rd, 32'hFFFF_FFFF);
		bus(32'h4, 32'hFFFF, 1'b1);
		bus(32'h10, 32'h0, 1'b0);
		chk(rd, 32'h0);
		bus(32'h4, 32'h0, 1'b0);
		chk(rd, 32'h0);
	endtask
	task automatic t_disc;
		op(32'h5, 32'hF);
		pwr <= 32'hF;
		refuse(32'h5);
		refuse(32'h1234);
		pwr <= 32'hFFFF_FFFF;
		repeat (4) @(posedge clk);
		op(32'hFFF6, 32'hFFFF_FDFF);
		chk(pres, 32'hFFFF_FFFF);
	endtask
	task automatic t_sim;
		logic [31:0] c [2];
		c = '{32'hFFEC, 32'hFFEB};
		for (int i = 0; i < 2; i++) begin
			op(c[i], links);
			chk(mode, 32'h1);
			bus(32'h8, 32'h0, 1'b0);
			chk(rd, {30'h0, i == 0, 1'b1});
			chk(fsa, 32'(i));
			refuse(32'h5);
			refuse(32'hFFF6);
			refuse(c[1-i]);
			op(32'hFFE7, links);
			chk(mode, 32'h0);
		end
	endtask
	task automatic t_drv;
		drv <= 1'b1;
		refuse(32'h3);
		op(32'h1, 32'h0);
		op(32'hFFF6, 32'h1);
		drv <= 1'b0;
		op(32'hFFF6, 32'hFFFF_FDFF);
	endtask
	task automatic t_rst2;
		op(32'hFFEB, links);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		links = 32'hFFFF_FFFF;
		chk(mode, 32'h0);
		chk(conn, links);
		bus(32'h8, 32'h0, 1'b0);
		chk(rd, 32'h0);
		bus(32'h4, 32'h0, 1'b0);
		chk(rd, 32'h0);
	endtask
	task automatic complete_run;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_disc();
		t_sim();
		t_drv();
		t_rst2();
		complete_run();
	end
	initial begin
		#2000000;
		num_errors++;
		complete_run();
	end
endmodule
`default_nettype wire
